// file: rtl/dbp_cfg.svh
// Constants for the DDR2 burst and precharge core
`ifndef DBP_CFG_SVH
`define DBP_CFG_SVH

// ----------------------------------------
// Organisation
// ----------------------------------------
`define DBP_BANKS 4
`define DBP_BA_W 2
`define DBP_DQ_W 16
`define DBP_DM_W 2
`define DBP_LAT_W 3
`define DBP_CNT_W 5

// ----------------------------------------
// Write beat schedule
// ----------------------------------------
`define DBP_SLOTS 16
`define DBP_SLOT_W 4
`define DBP_MAX_BEATS 4
`define DBP_WL_OFS 4'h1

// ----------------------------------------
// Timing counts in link clocks
// ----------------------------------------
`define DBP_BEATS_BL4 5'h02
`define DBP_BEATS_BL8 5'h04
`define DBP_RTP_FLOOR 5'h02
`define DBP_BL8_OFS 5'h02
`define DBP_CNT_ONE 5'h01
`define DBP_CNT_RST 5'h00

`endif

// file: rtl/dbp_pkg.sv
// Types shared by the DDR2 burst and precharge core
package dbp_pkg;
`include "dbp_cfg.svh"

  // Decoded command on the link
  typedef enum logic [2:0] {
    DBP_NOP,
    DBP_ACT,
    DBP_RD,
    DBP_WR,
    DBP_PRE
  } dbp_cmd_e;

  // One scheduled write beat pair
  typedef struct packed {
    logic v;
    logic [`DBP_BA_W-1:0] bank;
    logic ap_last;
  } dbp_slot_s;

  // Mode settings as carried across domains
  typedef struct packed {
    logic [`DBP_LAT_W-1:0] al;
    logic [`DBP_LAT_W-1:0] cl;
    logic bl8;
    logic [`DBP_CNT_W-1:0] tras;
    logic [`DBP_CNT_W-1:0] trtp;
    logic [`DBP_CNT_W-1:0] twr;
  } dbp_cfg_s;

  // Link clock domain state of the core
  typedef struct packed {
    dbp_cfg_s cfg_m;
    dbp_cfg_s cfg_s;
    dbp_slot_s [`DBP_SLOTS-1:0] slot;
    logic wr_en;
    logic [`DBP_BA_W-1:0] wr_bank;
    logic [2*`DBP_DQ_W-1:0] wr_data;
    logic [2*`DBP_DM_W-1:0] wr_be;
  } dbp_link_s;

  // System clock domain state of the core
  typedef struct packed {
    logic [`DBP_BANKS-1:0] open_m;
    logic [`DBP_BANKS-1:0] open_s;
  } dbp_sys_s;

  // Per bank state
  typedef struct packed {
    logic open;
    logic [`DBP_CNT_W-1:0] ras_cnt;
    logic [`DBP_CNT_W-1:0] rtp_cnt;
    logic [`DBP_CNT_W-1:0] ap_cnt;
    logic ap_rd;
    logic ap_wr;
    logic [`DBP_CNT_W-1:0] wr_cnt;
  } dbp_bank_s;

endpackage : dbp_pkg

// file: rtl/dbp_bank.sv
// One bank: open state, active lockout and auto-precharge timing
`timescale 1ns/1ps
`default_nettype none
`include "dbp_cfg.svh"

module dbp_bank
  import dbp_pkg::*;
(
  // Link clock and reset
  input wire logic ck,
  input wire logic resetn,
  // Commands for this bank
  input wire logic act,
  input wire logic pre,
  input wire logic rd_ap,
  input wire logic wr_ap_last,
  // Delays in link clocks
  input wire logic [`DBP_CNT_W-1:0] ap_delay,
  input wire logic [`DBP_CNT_W-1:0] rtp_delay,
  input wire logic [`DBP_CNT_W-1:0] tras,
  input wire logic [`DBP_CNT_W-1:0] twr,
  // Bank state
  output logic bank_open,
  output logic ap_fire
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  dbp_bank_s q; // Registered state
  dbp_bank_s next_q; // Next state

  // Step a counter down, holding at zero
  function automatic logic [`DBP_CNT_W-1:0] dec1(input logic [`DBP_CNT_W-1:0] v);
    dec1 = (v == `DBP_CNT_RST) ? `DBP_CNT_RST : v - `DBP_CNT_ONE;
  endfunction : dec1

  // Auto-precharge starts only once every hold-off has run out
  assign ap_fire = q.open && (q.ras_cnt == `DBP_CNT_RST) &&
                   ((q.ap_rd && q.ap_cnt == `DBP_CNT_RST && q.rtp_cnt == `DBP_CNT_RST) ||
                    (q.ap_wr && q.wr_cnt == `DBP_CNT_RST));
  assign bank_open = q.open;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_q = q;
    next_q.ras_cnt = dec1(q.ras_cnt);
    next_q.rtp_cnt = dec1(q.rtp_cnt);
    next_q.ap_cnt = dec1(q.ap_cnt);
    next_q.wr_cnt = dec1(q.wr_cnt);
    // Activate opens the row and restarts the lockout
    if (act) begin
      next_q.open = 1'b1;
      next_q.ras_cnt = dec1(tras);
      next_q.ap_rd = 1'b0;
      next_q.ap_wr = 1'b0;
    end
    // Read with auto-precharge arms the read timers
    if (rd_ap) begin
      next_q.ap_rd = 1'b1;
      next_q.ap_wr = 1'b0;
      next_q.ap_cnt = dec1(ap_delay);
      next_q.rtp_cnt = dec1(rtp_delay);
    end
    // Last beat of an auto-precharge write is stored
    if (wr_ap_last) begin
      next_q.ap_wr = 1'b1;
      next_q.wr_cnt = dec1(twr);
    end
    // Explicit or automatic precharge closes the bank
    if (ap_fire || pre) begin
      next_q.open = 1'b0;
      next_q.ap_rd = 1'b0;
      next_q.ap_wr = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ck or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ck); endclocking
  default disable iff (!resetn);

  property p_pre_close;
    pre |=> !bank_open;
  endproperty
  a_pre_close: assert property (p_pre_close) else $error("bank open after precharge");

  property p_ras_lock;
    act && (tras > `DBP_BEATS_BL4) |=> !ap_fire [*2];
  endproperty
  a_ras_lock: assert property (p_ras_lock) else $error("auto-precharge inside tRAS");

  property p_rtp_floor;
    rd_ap |=> !ap_fire;
  endproperty
  a_rtp_floor: assert property (p_rtp_floor) else $error("auto-precharge too early");

  property p_wr_store;
    wr_ap_last && (twr > `DBP_CNT_ONE) |=> !ap_fire;
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("precharge before write stored");

endmodule : dbp_bank
`default_nettype wire

// file: rtl/dbp_core.sv
// DDR2 write mask, burst interrupt and precharge core
//
// Behaviour
// - One mask per byte, masked byte unwritten
// - Mask ignored during read bursts
// - Interrupting command may target any bank
// - Interrupt may carry auto-precharge
// - A10 low closes one bank, high all
// - A10 selects auto-precharge after burst
// - Write precharge waits for stored data
// - Auto-precharge held until tRAS met
// - Read precharge at AL+BL/2, deferred
// - Precharge tRTP, at least two clocks, after last prefetch
// - RL is AL+CL, WL is RL-1
`timescale 1ns/1ps
`default_nettype none
`include "dbp_cfg.svh"

module dbp_core
  import dbp_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Mode settings, system clock domain
  input wire logic [`DBP_LAT_W-1:0] cfg_al,
  input wire logic [`DBP_LAT_W-1:0] cfg_cl,
  input wire logic cfg_bl8,
  input wire logic [`DBP_CNT_W-1:0] cfg_tras,
  input wire logic [`DBP_CNT_W-1:0] cfg_trtp,
  input wire logic [`DBP_CNT_W-1:0] cfg_twr,
  // Bank state, system clock domain
  output logic [`DBP_BANKS-1:0] bank_open,
  // Link clock and command pins
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`DBP_BA_W-1:0] ba,
  input wire logic a10,
  // Write data and mask, both halves of one clock
  input wire logic [`DBP_DQ_W-1:0] wd_rise,
  input wire logic [`DBP_DQ_W-1:0] wd_fall,
  input wire logic [`DBP_DM_W-1:0] dm_rise,
  input wire logic [`DBP_DM_W-1:0] dm_fall,
  // Array write port, link clock domain
  output logic arr_wr_en,
  output logic [`DBP_BA_W-1:0] arr_wr_bank,
  output logic [2*`DBP_DQ_W-1:0] arr_wr_data,
  output logic [2*`DBP_DM_W-1:0] arr_wr_be,
  // Auto-precharge start, link clock domain
  output logic [`DBP_BANKS-1:0] bank_ap_start
);

  // ----------------------------------------
  // State and decode signals
  // ----------------------------------------
  dbp_link_s q; // Link domain state
  dbp_link_s next_q; // Link domain next state
  dbp_sys_s s; // System domain state
  dbp_sys_s next_s; // System domain next state
  dbp_cfg_s cfg_in; // Settings before crossing
  dbp_cmd_e cmd; // Command of this link clock
  logic [`DBP_SLOT_W-1:0] wl; // Write latency
  logic [`DBP_CNT_W-1:0] beats; // Clocks per full burst
  logic [`DBP_CNT_W-1:0] rtp_eff; // tRTP with floor
  logic [`DBP_CNT_W-1:0] ap_delay; // Read to auto-precharge
  logic [`DBP_CNT_W-1:0] rtp_delay; // Read to tRTP end
  logic [`DBP_BANKS-1:0] open_ck; // Bank open, link domain
  logic [`DBP_BANKS-1:0] act_b; // Activate per bank
  logic [`DBP_BANKS-1:0] pre_b; // Precharge per bank
  logic [`DBP_BANKS-1:0] rd_ap_b; // Read with AP per bank
  logic [`DBP_BANKS-1:0] wr_ap_b; // Last AP write beat
  logic any_slot; // Write beats pending

  // Command pins to command
  function automatic dbp_cmd_e dbp_decode(
    input logic sel_n,
    input logic row_n,
    input logic col_n,
    input logic wen_n
  );
    dbp_decode = DBP_NOP;
    if (!sel_n) begin
      unique case ({row_n, col_n, wen_n})
        3'h3: dbp_decode = DBP_ACT;
        3'h5: dbp_decode = DBP_RD;
        3'h4: dbp_decode = DBP_WR;
        3'h2: dbp_decode = DBP_PRE;
        // Refresh, mode set and no operation
        default: dbp_decode = DBP_NOP;
      endcase
    end
  endfunction : dbp_decode

  assign cmd = dbp_decode(cs_n, ras_n, cas_n, we_n);
  assign cfg_in = {cfg_al, cfg_cl, cfg_bl8, cfg_tras, cfg_trtp, cfg_twr};

  // ----------------------------------------
  // Latencies from the synchronised settings
  // ----------------------------------------
  // Write latency is one less than AL plus CL
  assign wl = `DBP_SLOT_W'(q.cfg_s.al) + `DBP_SLOT_W'(q.cfg_s.cl)
              - `DBP_WL_OFS;
  // Timing always follows the programmed length
  assign beats = q.cfg_s.bl8 ? `DBP_BEATS_BL8 : `DBP_BEATS_BL4;
  // Never closer than two clocks to the prefetch
  assign rtp_eff = (q.cfg_s.trtp > `DBP_RTP_FLOOR) ? q.cfg_s.trtp
                   : `DBP_RTP_FLOOR;
  assign ap_delay = `DBP_CNT_W'(q.cfg_s.al) + beats;
  // Last prefetch sits two clocks later at length eight
  assign rtp_delay = `DBP_CNT_W'(q.cfg_s.al)
                     + (q.cfg_s.bl8 ? `DBP_BL8_OFS : `DBP_CNT_RST)
                     + rtp_eff;

  // ----------------------------------------
  // Per bank command strobes
  // ----------------------------------------
  always_comb begin
    any_slot = 1'b0;
    for (int b = 0; b < `DBP_BANKS; b++) begin
      act_b[b] = (cmd == DBP_ACT) && (ba == `DBP_BA_W'(b));
      // A10 high selects every bank
      pre_b[b] = (cmd == DBP_PRE) && (a10 || ba == `DBP_BA_W'(b));
      // A10 high on a read arms auto-precharge
      rd_ap_b[b] = (cmd == DBP_RD) && a10 && (ba == `DBP_BA_W'(b));
      // Write recovery starts once the last beat is stored
      wr_ap_b[b] = q.slot[0].v && q.slot[0].ap_last
                   && (q.slot[0].bank == `DBP_BA_W'(b));
    end
    for (int i = 0; i < `DBP_SLOTS; i++) begin
      any_slot = any_slot | q.slot[i].v;
    end
  end

  // ----------------------------------------
  // Link domain next state
  // ----------------------------------------
  always_comb begin
    next_q = q;
    // Quasi-static settings cross on two flops
    next_q.cfg_m = cfg_in;
    next_q.cfg_s = q.cfg_m;
    // Beat schedule moves one clock closer
    next_q.slot = {dbp_slot_s'('0), q.slot[`DBP_SLOTS-1:1]};
    // Capture the beat pair that is due now
    next_q.wr_en = q.slot[0].v;
    if (q.slot[0].v) begin
      next_q.wr_bank = q.slot[0].bank;
      next_q.wr_data = {wd_fall, wd_rise};
      // A high mask bit keeps its byte out
      next_q.wr_be = ~{dm_fall, dm_rise};
    end
    // A write books its beats; a later one overwrites the tail
    if (cmd == DBP_WR) begin
      for (int j = 0; j < `DBP_MAX_BEATS; j++) begin
        if (`DBP_CNT_W'(j) < beats) begin
          next_q.slot[wl + `DBP_SLOT_W'(j)].v = 1'b1;
          next_q.slot[wl + `DBP_SLOT_W'(j)].bank = ba;
          next_q.slot[wl + `DBP_SLOT_W'(j)].ap_last =
            a10 && (`DBP_CNT_W'(j) == beats - `DBP_CNT_ONE);
        end
      end
    end
  end

  // ----------------------------------------
  // Link domain registers
  // ----------------------------------------
  always_ff @(posedge ck or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Reads book no beats, so the mask goes unseen
  assign arr_wr_en = q.wr_en;
  assign arr_wr_bank = q.wr_bank;
  assign arr_wr_data = q.wr_data;
  assign arr_wr_be = q.wr_be;

  // ----------------------------------------
  // Banks
  // ----------------------------------------
  generate
    for (genvar g = 0; g < `DBP_BANKS; g++) begin : g_bank
      dbp_bank u_bank (
        .ck(ck),
        .resetn(resetn),
        .act(act_b[g]),
        .pre(pre_b[g]),
        .rd_ap(rd_ap_b[g]),
        .wr_ap_last(wr_ap_b[g]),
        .ap_delay(ap_delay),
        .rtp_delay(rtp_delay),
        .tras(q.cfg_s.tras),
        .twr(q.cfg_s.twr),
        .bank_open(open_ck[g]),
        .ap_fire(bank_ap_start[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // System domain status
  // ----------------------------------------
  // Each bank bit is a level, so two flops suffice
  always_comb begin
    next_s = s;
    next_s.open_m = open_ck;
    next_s.open_s = s.open_m;
  end

  // System domain registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bank_open = s.open_s;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ck); endclocking
  default disable iff (!resetn);

  property p_mask_bytes;
    q.slot[0].v |=> arr_wr_en && (arr_wr_be == ~$past({dm_fall, dm_rise}));
  endproperty
  a_mask_bytes: assert property (p_mask_bytes) else $error("mask not applied");

  property p_rd_no_mask;
    (cmd == DBP_RD) && !any_slot |=> !arr_wr_en [*2];
  endproperty
  a_rd_no_mask: assert property (p_rd_no_mask) else $error("write during read");

  property p_pre_all;
    (cmd == DBP_PRE) && a10 |=> (open_ck == '0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("bank open after all");

  property p_rd_keep;
    (cmd == DBP_RD) && !a10 && open_ck[ba] && !bank_ap_start[ba]
      |=> open_ck[$past(ba)];
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("read closed bank");

  property p_wl_slot;
    (cmd == DBP_WR) |=> q.slot[$past(wl)].v && (q.slot[$past(wl)].bank == $past(ba));
  endproperty
  a_wl_slot: assert property (p_wl_slot) else $error("write beat misplaced");

endmodule : dbp_core
`default_nettype wire

// file: tb/dbp_ctl_model.sv
// Memory controller model driving commands and write beats
`timescale 1ns/1ps
`default_nettype none
`include "dbp_cfg.svh"

module dbp_ctl_model
  import dbp_pkg::*;
#(
  parameter int WL = 2
)
(
  // Link clock
  input wire logic ck,
  // Command pins
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [`DBP_BA_W-1:0] ba,
  output logic a10,
  // Write beats and masks
  output logic [`DBP_DQ_W-1:0] wd_rise,
  output logic [`DBP_DQ_W-1:0] wd_fall,
  output logic [`DBP_DM_W-1:0] dm_rise,
  output logic [`DBP_DM_W-1:0] dm_fall
);
  int cnt; // Link edges seen
  logic [36:0] sched [0:255]; // Valid, mask and beat pair per edge

  // Quiet pins at time zero
  initial begin
    cnt = 0;
    {cs_n, ras_n, cas_n, we_n, ba, a10} = 7'h7f;
    {dm_fall, dm_rise, wd_fall, wd_rise} = 36'h0;
    foreach (sched[i]) sched[i] = 37'h0;
  end

  // Beat driver; idle data lines toggle so a stale beat never looks valid
  always @(posedge ck) begin
    cnt <= cnt + 1;
    if (sched[cnt[7:0]][36]) begin
      {dm_fall, dm_rise, wd_fall, wd_rise} <= sched[cnt[7:0]][35:0];
      sched[cnt[7:0]] <= 37'h0;
    end else begin
      {dm_fall, dm_rise, wd_fall, wd_rise} <= ~{dm_fall, dm_rise, wd_fall, wd_rise};
    end
  end

  // One command, taken at the edge returned in tc
  task automatic issue(input logic [2:0] code, input logic [1:0] bank, input logic ap,
                       output int tc);
    @(posedge ck);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n, ba, a10} <= {code, bank, ap};
    @(posedge ck);
    tc = cnt;
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n, ba, a10} <= ~{code, bank, ap};
  endtask : issue

  // Burst of eight; a write two edges later replaces the tail pairs
  task automatic write8(input logic [1:0] bank, input logic ap, input logic [15:0] base,
                        input logic [3:0] m, output int tc);
    issue(3'b100, bank, ap, tc);
    for (int j = 0; j < 4; j++) begin
      sched[(tc + WL + j) % 256] = {1'b1, m, base + 16'(2 * j + 1), base + 16'(2 * j)};
    end
  endtask : write8
endmodule : dbp_ctl_model
`default_nettype wire

// file: tb/dbp_core_tb.sv
// Testbench for the burst and precharge core
`timescale 1ns/1ps
`default_nettype none
`include "dbp_cfg.svh"

module dbp_core_tb
  import dbp_pkg::*;
;
  localparam logic [2:0] C_ACT = 3'b011;
  localparam logic [2:0] C_RD = 3'b101;
  localparam logic [2:0] C_PRE = 3'b010;
  logic clk = 1'b0;
  logic ck, resetn, cfg_bl8, cs_n, ras_n, cas_n, we_n, a10, arr_wr_en;
  logic [2:0] cfg_al, cfg_cl;
  logic [4:0] cfg_tras, cfg_trtp, cfg_twr;
  logic [3:0] bank_open, bank_ap_start, arr_wr_be, exp_open;
  logic [1:0] ba, arr_wr_bank, dm_rise, dm_fall;
  logic [15:0] wd_rise, wd_fall;
  logic [31:0] arr_wr_data;
  int error_cnt, tests_run, tc, tc2, ta;
  int ap_at [0:3]; // Edge of each bank's last precharge start
  logic [37:0] seen [$]; // Array writes as {bank, data, enables}

  dbp_core dut_u (.clk, .resetn, .cfg_al, .cfg_cl, .cfg_bl8, .cfg_tras, .cfg_trtp,
    .cfg_twr, .bank_open, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .a10, .wd_rise,
    .wd_fall, .dm_rise, .dm_fall, .arr_wr_en, .arr_wr_bank, .arr_wr_data, .arr_wr_be,
    .bank_ap_start);
  dbp_ctl_model #(.WL(2)) ctl_u (.ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .a10,
    .wd_rise, .wd_fall, .dm_rise, .dm_fall);

  // System clock, and a link clock of unrelated phase
  always #10 clk = ~clk;
  initial begin
    ck = 1'b0;
    #7;
    forever #32 ck = ~ck;
  end

  // Log array writes and precharge starts per link edge
  always @(posedge ck) begin
    for (int b = 0; b < 4; b++) if (bank_ap_start[b] === 1'b1) ap_at[b] = ctl_u.cnt;
    if (arr_wr_en === 1'b1) seen.push_back({arr_wr_bank, arr_wr_data, arr_wr_be});
  end

  // Compare and count
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Let link edges pass, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge ck);
    @(negedge ck);
  endtask : cyc

  // Wait for bank state to cross into the system domain
  task automatic settle;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Next array write must be pair j of the given burst
  task automatic expect_wr(input logic [1:0] b, input logic [15:0] base, input logic [3:0] m,
                           input int j);
    check(40'(seen.pop_front()), 40'({b, base + 16'(2 * j + 1), base + 16'(2 * j), ~m}));
  endtask : expect_wr

  // Verdict and end of run
  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Watchdog
  initial begin
    #60000;
    error_cnt++;
    final_report;
  end

  // Main sequence: AL 0, CL 3 so WL 2, burst of eight
  initial begin
    resetn = 1'b0;
    {cfg_al, cfg_cl, cfg_bl8} = {3'h0, 3'h3, 1'b1};
    {cfg_tras, cfg_trtp, cfg_twr} = {5'h0a, 5'h05, 5'h02};
    error_cnt = 0;
    tests_run = 0;
    foreach (ap_at[i]) ap_at[i] = -1;
    repeat (7) @(posedge clk);
    resetn <= 1'b1;
    cyc(3);
    check(40'({bank_open, arr_wr_en, bank_ap_start}), 40'h0);
    for (int b = 0; b < 4; b++) ctl_u.issue(C_ACT, 2'(b), 1'b0, tc);
    settle;
    check(40'(bank_open), 40'hf);
    // Masked write, one mask bit per byte
    ctl_u.write8(2'h1, 1'b0, 16'h1000, 4'h6, tc);
    cyc(8);
    check(40'(seen.size()), 40'h4);
    for (int j = 0; j < 4; j++) expect_wr(2'h1, 16'h1000, 4'h6, j);
    // Read interrupted by a read with precharge to another bank
    ctl_u.issue(C_RD, 2'h0, 1'b0, tc);
    ctl_u.issue(C_RD, 2'h1, 1'b1, tc);
    cyc(10);
    check(40'(seen.size()), 40'h0);
    check(40'(ap_at[1] - tc), 40'h7);
    settle;
    check(40'(bank_open), 40'hd);
    // Read with precharge right after activate waits for active time
    cyc(4);
    ctl_u.issue(C_ACT, 2'h1, 1'b0, ta);
    ctl_u.issue(C_RD, 2'h1, 1'b1, tc);
    cyc(12);
    check(40'(ap_at[1] - ta), 40'ha);
    // Write interrupted by a write with precharge to another bank
    ctl_u.write8(2'h2, 1'b0, 16'h2000, 4'h0, tc);
    ctl_u.write8(2'h3, 1'b1, 16'h3000, 4'h9, tc2);
    cyc(12);
    check(40'(seen.size()), 40'h6);
    for (int j = 0; j < 2; j++) expect_wr(2'h2, 16'h2000, 4'h0, j);
    for (int j = 0; j < 4; j++) expect_wr(2'h3, 16'h3000, 4'h9, j);
    check(40'(ap_at[3] - tc2), 40'h8);
    settle;
    check(40'(bank_open), 40'h5);
    // Single bank precharge, each bank in turn
    ctl_u.issue(C_ACT, 2'h1, 1'b0, tc);
    ctl_u.issue(C_ACT, 2'h3, 1'b0, tc);
    cyc(12);
    exp_open = 4'hf;
    for (int b = 0; b < 4; b++) begin
      ctl_u.issue(C_PRE, 2'(b), 1'b0, tc);
      exp_open[b] = 1'b0;
      settle;
      check(40'(bank_open), 40'(exp_open));
    end
    // Precharge of all banks ignores the bank bits
    for (int b = 0; b < 4; b++) ctl_u.issue(C_ACT, 2'(b), 1'b0, tc);
    cyc(12);
    ctl_u.issue(C_PRE, 2'h2, 1'b1, tc);
    settle;
    check(40'(bank_open), 40'h0);
    // Length four read with precharge: tRTP counts from the read itself
    cfg_bl8 <= 1'b0;
    cyc(4);
    ctl_u.issue(C_ACT, 2'h0, 1'b0, ta);
    cyc(12);
    ctl_u.issue(C_RD, 2'h0, 1'b1, tc);
    cyc(8);
    check(40'(ap_at[0] - tc), 40'h5);
    settle;
    check(40'(bank_open), 40'h0);
    final_report;
  end
endmodule : dbp_core_tb
`default_nettype wire
